// ### common/usdp_pkg.sv
// Purpose: shared constants and carriers of the uart shadow data port
// Assumes: 32-bit apb, byte addresses as printed
// Notes:   control, status and level words sit just above the shadow block
package usdp_pkg;

   localparam int          WORD_BYTES   = 4;
   localparam int          SHADOW_WORDS = 16;
   localparam int          FIFO_DEPTH   = 16;
   localparam int          CHAR_W       = 8;

   localparam logic [31:0] DATA5_ADDR   = 32'h5000_1144;
   localparam logic [31:0] DATA6_ADDR   = 32'h5000_1148;
   localparam logic [31:0] SHADOW_BASE  = DATA5_ADDR - 32'(5 * WORD_BYTES);
   localparam logic [31:0] SHADOW_END   = SHADOW_BASE + 32'(SHADOW_WORDS * WORD_BYTES);
   localparam logic [31:0] CTRL_ADDR    = SHADOW_END;
   localparam logic [31:0] STAT_ADDR    = SHADOW_END + 32'(WORD_BYTES);
   localparam logic [31:0] LEVEL_ADDR   = SHADOW_END + 32'(2 * WORD_BYTES);
   localparam logic [31:0] ALIGN_MASK   = 32'h0000_0003;

   localparam logic [7:0]  DATA_RESET   = 8'h00;
   localparam logic [7:0]  CTRL_RESET   = 8'h00;
   localparam logic [7:0]  CTRL_MASK    = 8'h03;
   localparam int          CTRL_FIFO_EN = 0;
   localparam int          CTRL_IR_MODE = 1;

   localparam int          STAT_DR      = 0;
   localparam int          STAT_OVR     = 1;
   localparam int          STAT_TX_FULL = 2;
   localparam int          STAT_RX_FULL = 3;
   localparam int          STAT_TX_HOLDING_EMPTY    = 5;
   localparam int          LEVEL_TX_LSB = 16;

   typedef struct packed {
      logic [31:0] paddr;
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [31:0] pwdata;
   } usdp_apb_req_type;

   typedef struct packed {
      logic              valid;
      logic [CHAR_W-1:0] data;
   } usdp_char_type;

endpackage

// ### hdl/usdp_fifo.sv
// Purpose: synchronous fifo in flip-flops with valid/ready on both sides
// Assumes: one clock, flush empties it in one cycle
// Notes:   head data is combinational from the storage array
`timescale 1ns/1ps
module usdp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int CW    = $clog2(DEPTH + 1)
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             flush,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready,
   output logic      [CW-1:0]    count
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_r;
   logic [AW-1:0]    rd_r;
   logic [CW-1:0]    cnt_r;

   wire push = in_valid && in_ready;
   wire pop  = out_valid && out_ready;

   assign in_ready  = (cnt_r != CW'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data  = mem_r[rd_r];
   assign count     = cnt_r;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else if (flush) begin
         wr_r  <= '0;
         rd_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == LAST) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == LAST) ? '0 : rd_r + 1'b1;
         end
         cnt_r <= cnt_r + CW'(push) - CW'(pop);
      end
   end
endmodule

// ### hdl/usdp_skid.sv
// Purpose: two-entry buffer between the transmit source and the serializer
// Assumes: in_ready and out side come straight from flip-flops
// Notes:   a stall on out_ready loses nothing; second entry absorbs it
`timescale 1ns/1ps
module usdp_skid #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   logic             main_v_r;
   logic [WIDTH-1:0] main_d_r;
   logic             spare_v_r;
   logic [WIDTH-1:0] spare_d_r;

   wire take = in_valid && !spare_v_r;
   wire give = main_v_r && out_ready;

   assign in_ready  = !spare_v_r;
   assign out_valid = main_v_r;
   assign out_data  = main_d_r;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         main_v_r  <= 1'b0;
         main_d_r  <= '0;
         spare_v_r <= 1'b0;
         spare_d_r <= '0;
      end else begin
         if (give) begin
            main_v_r <= spare_v_r;
            main_d_r <= spare_d_r;
            spare_v_r <= 1'b0;
         end
         if (take && (!main_v_r || give)) begin
            main_v_r <= 1'b1;
            main_d_r <= in_data;
         end else if (take) begin
            spare_v_r <= 1'b1;
            spare_d_r <= in_data;
         end
      end
   end
endmodule

// ### hdl/usdp_port.sv
// Purpose: shadow receive/transmit data port of a uart, apb slave
// Assumes: deserializer and serializer on clk, 125 MHz, one char per strobe
// Notes:   one wait state on every apb access
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module usdp_port #(
   parameter int RX_DEPTH = usdp_pkg::FIFO_DEPTH,
   parameter int TX_DEPTH = usdp_pkg::FIFO_DEPTH
) (
   input  wire logic                       clk,
   input  wire logic                       resetn,
   input  wire usdp_pkg::usdp_apb_req_type apb_req,
   output logic [31:0]                     prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire usdp_pkg::usdp_char_type    rx_sin_char,
   input  wire usdp_pkg::usdp_char_type    rx_sir_char,
   output usdp_pkg::usdp_char_type         tx_char,
   input  wire logic                       tx_char_ready,
   output logic                            ir_mode
);
   import usdp_pkg::*;

   localparam int RCW = $clog2(RX_DEPTH + 1);
   localparam int TCW = $clog2(TX_DEPTH + 1);

   logic [31:0]       prdata_r;
   logic              pready_r;
   logic              pslverr_r;
   logic [7:0]        ctrl_r;
   logic [CHAR_W-1:0] rbr_r;
   logic              dr_r;
   logic              ovr_r;
   logic [CHAR_W-1:0] thr_r;
   logic              thr_full_r;

   // ---- apb decode
   wire [31:0] addr      = apb_req.paddr;
   wire        aligned   = (addr & ALIGN_MASK) == '0;
   wire        hit_data  = aligned && (addr >= SHADOW_BASE) && (addr < SHADOW_END);
   wire        hit_ctrl  = (addr == CTRL_ADDR);
   wire        hit_stat  = (addr == STAT_ADDR);
   wire        hit_level = (addr == LEVEL_ADDR);
   wire        hit_any   = hit_data || hit_ctrl || hit_stat || hit_level;
   // effects land on the first access edge, answer shows one edge later
   wire        cap       = apb_req.psel && apb_req.penable && !pready_r;
   wire        rd_data   = cap && !apb_req.pwrite && hit_data;
   wire        wr_data   = cap && apb_req.pwrite && hit_data;
   wire        wr_ctrl   = cap && apb_req.pwrite && hit_ctrl;
   wire        rd_stat   = cap && !apb_req.pwrite && hit_stat;
   wire        unmapped  = cap && !hit_any;

   wire        fifo_en   = ctrl_r[CTRL_FIFO_EN];
   wire        ir_sel    = ctrl_r[CTRL_IR_MODE];
   wire [7:0]  ctrl_nxt  = apb_req.pwdata[7:0] & CTRL_MASK;
   // changing fifo mode empties both fifos; stale chars already in the skid buffer still go out
   wire        flush     = wr_ctrl && (ctrl_nxt[CTRL_FIFO_EN] != fifo_en);

   // ---- receive side
   usdp_char_type     rx_in;
   logic              rxf_in_ready;
   logic              rxf_valid;
   logic [CHAR_W-1:0] rxf_data;
   logic [RCW-1:0]    rxf_count;

   assign rx_in = ir_sel ? rx_sir_char : rx_sin_char;

   wire rx_take  = rx_in.valid;
   // a pop in the same cycle frees no slot for the arrival
   wire rx_lost  = rx_take && (fifo_en ? !rxf_in_ready : (dr_r && !rd_data));
   wire dr       = fifo_en ? rxf_valid : dr_r;
   wire [CHAR_W-1:0] rx_head = fifo_en ? (rxf_valid ? rxf_data : DATA_RESET) : rbr_r;

   usdp_fifo #(
      .WIDTH (CHAR_W),
      .DEPTH (RX_DEPTH)
   ) u_rx_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .flush     (flush),
      .in_valid  (fifo_en && rx_take),
      .in_data   (rx_in.data),
      .in_ready  (rxf_in_ready),
      .out_valid (rxf_valid),
      .out_data  (rxf_data),
      .out_ready (fifo_en && rd_data),
      .count     (rxf_count)
   );

   // ---- transmit side
   logic              txf_in_ready;
   logic              txf_valid;
   logic [CHAR_W-1:0] txf_data;
   logic [TCW-1:0]    txf_count;
   logic              sk_in_ready;
   logic              sk_valid;
   logic [CHAR_W-1:0] sk_data;

   wire              sk_in_valid = fifo_en ? txf_valid : thr_full_r;
   wire [CHAR_W-1:0] sk_in_data  = fifo_en ? txf_data : thr_r;
   wire              thr_take    = !fifo_en && thr_full_r && sk_in_ready;
   wire              tx_holding_empty        = fifo_en ? !txf_valid : !thr_full_r;
   wire              txf_pop     = fifo_en && txf_valid && sk_in_ready;

   usdp_fifo #(
      .WIDTH (CHAR_W),
      .DEPTH (TX_DEPTH)
   ) u_tx_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .flush     (flush),
      .in_valid  (fifo_en && wr_data),
      .in_data   (apb_req.pwdata[CHAR_W-1:0]),
      .in_ready  (txf_in_ready),
      .out_valid (txf_valid),
      .out_data  (txf_data),
      .out_ready (fifo_en && sk_in_ready),
      .count     (txf_count)
   );

   // two entries so a stalled serializer holds up the holding register only once both are full
   usdp_skid #(
      .WIDTH (CHAR_W)
   ) u_tx_skid (
      .clk       (clk),
      .resetn    (resetn),
      .in_valid  (sk_in_valid),
      .in_data   (sk_in_data),
      .in_ready  (sk_in_ready),
      .out_valid (sk_valid),
      .out_data  (sk_data),
      .out_ready (tx_char_ready)
   );

   // ---- read mux
   logic [31:0] stat_word;
   logic [31:0] level_word;
   logic [31:0] rd_word;

   always_comb begin
      stat_word               = '0;
      stat_word[STAT_DR]      = dr;
      stat_word[STAT_OVR]     = ovr_r;
      stat_word[STAT_TX_FULL] = fifo_en && !txf_in_ready;
      stat_word[STAT_RX_FULL] = fifo_en && !rxf_in_ready;
      stat_word[STAT_TX_HOLDING_EMPTY]    = tx_holding_empty;
   end

   assign level_word = 32'(rxf_count) | (32'(txf_count) << LEVEL_TX_LSB);
   assign rd_word    = hit_data  ? 32'(rx_head) :
                       hit_ctrl  ? 32'(ctrl_r)  :
                       hit_stat  ? stat_word    :
                       hit_level ? level_word   : '0;

   // ---- apb answer
   // prdata holds between reads, so a late sampler still sees the last word
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= '0;
      end else begin
         pready_r  <= cap;
         pslverr_r <= unmapped;
         if (cap && !apb_req.pwrite) begin
            prdata_r <= rd_word;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // receive buffer for fifo-off mode; a read and an arrival together keep dr
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rbr_r <= DATA_RESET;
         dr_r  <= 1'b0;
      end else if (!fifo_en && rx_take) begin
         rbr_r <= rx_in.data;
         dr_r  <= 1'b1;
      end else if (!fifo_en && rd_data) begin
         dr_r  <= 1'b0;
      end else if (flush) begin
         dr_r  <= 1'b0;
      end
   end

   // overrun is sticky; status read clears it, a new loss in that cycle wins
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ovr_r <= 1'b0;
      end else if (rx_lost) begin
         ovr_r <= 1'b1;
      end else if (rd_stat) begin
         ovr_r <= 1'b0;
      end
   end

   // holding register for fifo-off mode; write wins over hand-off
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         thr_r      <= DATA_RESET;
         thr_full_r <= 1'b0;
      end else if (!fifo_en && wr_data) begin
         thr_r      <= apb_req.pwdata[CHAR_W-1:0];
         thr_full_r <= 1'b1;
      end else if (thr_take || flush) begin
         thr_full_r <= 1'b0;
      end
   end

   assign prdata        = prdata_r;
   assign pready        = pready_r;
   assign pslverr       = pslverr_r;
   assign tx_char       = usdp_char_type'{valid: sk_valid, data: sk_data};
   assign ir_mode       = ctrl_r[CTRL_IR_MODE];

   // ---- checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_alias_answer: assert property (
      (cap && hit_data) |=> (pready_r && !pslverr_r) ##1 !pready_r)
      else $error("shadow access not answered as mapped");

   a_rx_path_sel: assert property (
      (!fifo_en && rx_take) |=> (rbr_r == $past(ir_sel ? rx_sir_char.data
                                                        : rx_sin_char.data)))
      else $error("receive char taken from wrong line");

   a_rx_overwrite: assert property (
      (!fifo_en && rx_take && dr_r && !rd_data && !rd_stat) |=> (ovr_r && dr_r))
      else $error("overwrite without overrun");

   a_rx_fifo_pop: assert property (
      (fifo_en && rd_data && rxf_valid && !flush && !rx_take)
         |=> (prdata_r[CHAR_W-1:0] == $past(rxf_data))
             && (rxf_count == $past(rxf_count) - 1'b1))
      else $error("fifo read did not return and pop head");

   a_rx_full_keep: assert property (
      (fifo_en && rx_take && !rxf_in_ready && !rd_data && !rd_stat && !wr_ctrl)
         |=> (ovr_r && rxf_count == $past(rxf_count) && rxf_data == $past(rxf_data)))
      else $error("full receive fifo changed or no overrun");

   a_tx_holding_empty_clear: assert property (
      (!fifo_en && wr_data && tx_holding_empty && !wr_ctrl) |=> !tx_holding_empty ##1 (tx_char.valid || !tx_holding_empty))
      else $error("single write did not clear holding empty");

   a_thr_replace: assert property (
      (!fifo_en && wr_data && thr_full_r && !sk_in_ready)
         |=> (thr_r == $past(apb_req.pwdata[CHAR_W-1:0])) && thr_full_r)
      else $error("held char not replaced");

   a_tx_depth: assert property (
      (fifo_en && wr_data && (txf_count < TCW'(TX_DEPTH)) && !txf_pop)
         |=> (txf_count == $past(txf_count) + 1'b1))
      else $error("transmit fifo refused a write below its depth");

   a_tx_full_drop: assert property (
      (fifo_en && wr_data && !txf_in_ready && !txf_pop)
         |=> (txf_count == $past(txf_count)) && $stable(txf_data))
      else $error("write to full transmit fifo altered it");

   a_upper_zero: assert property (
      (pready_r && $past(hit_data) && !$past(apb_req.pwrite))
         |-> (prdata_r[31:CHAR_W] == '0))
      else $error("shadow read upper bits not zero");

   a_unmapped_err: assert property (
      (cap && !hit_any) |=> (pready_r && pslverr_r))
      else $error("unmapped access not refused");

   a_err_with_ready: assert property (
      pslverr_r |-> pready_r)
      else $error("error flag without ready");

   a_rx_read_data: assert property (
      (!fifo_en && rd_data) |=> (prdata_r[CHAR_W-1:0] == $past(rbr_r)))
      else $error("buffer read returned wrong char");

   a_rx_read_clear: assert property (
      (!fifo_en && rd_data && !rx_take) |=> !dr_r)
      else $error("buffer read left data ready set");

   a_ovr_sticky: assert property (
      (ovr_r && !rd_stat) |=> ovr_r)
      else $error("overrun cleared without status read");

   a_rx_fifo_push: assert property (
      (fifo_en && rx_take && rxf_in_ready && !rd_data && !flush)
         |=> (rxf_count == $past(rxf_count) + 1'b1))
      else $error("receive fifo lost an arrival with room left");

   a_rx_empty_zero: assert property (
      (fifo_en && rd_data && !rxf_valid) |=> (prdata_r[CHAR_W-1:0] == DATA_RESET))
      else $error("empty receive fifo read not zero");

   a_flush_empty: assert property (
      flush |=> (rxf_count == '0) && (txf_count == '0) && !thr_full_r)
      else $error("mode change left stale chars");

   a_rx_full_stat: assert property (
      stat_word[STAT_RX_FULL] == (fifo_en && (rxf_count == RCW'(RX_DEPTH))))
      else $error("receive full status disagrees with level");

   a_tx_hold_char: assert property (
      (tx_char.valid && !tx_char_ready) |=> (tx_char.valid && $stable(tx_char.data)))
      else $error("stalled transmit char dropped or changed");

   a_thr_load: assert property (
      (!fifo_en && wr_data)
         |=> (thr_full_r && (thr_r == $past(apb_req.pwdata[CHAR_W-1:0]))))
      else $error("write did not load holding register");

   a_thr_keep: assert property (
      (!fifo_en && thr_full_r && !sk_in_ready && !wr_data && !flush)
         |=> (thr_full_r && $stable(thr_r)))
      else $error("held char lost while buffer stalled");

   a_tx_full_stat: assert property (
      (fifo_en && (txf_count == TCW'(TX_DEPTH))) |-> stat_word[STAT_TX_FULL])
      else $error("full transmit fifo not reported");

   a_tx_holding_empty_fifo: assert property (
      (fifo_en && wr_data && txf_in_ready) |=> !tx_holding_empty)
      else $error("holding empty set after accepted write");
endmodule

// ### verification/usdp_line_model.sv
// Purpose: far side of the shadow port, deserializer and serializer stand-in
// Assumes: one char per valid pulse, same clock as the port
// Notes:   idle rx data toggles so a stale byte never looks new
`timescale 1ns/1ps
module usdp_line_model (
   input  wire logic                    clk,
   input  wire logic                    resetn,
   input  wire logic                    ir_mode,
   input  wire usdp_pkg::usdp_char_type tx_char,
   output logic                         tx_char_ready,
   output usdp_pkg::usdp_char_type      rx_sin_char,
   output usdp_pkg::usdp_char_type      rx_sir_char,
   input  wire logic                    stall
);
   import usdp_pkg::*;
   logic [7:0] got_q[$];
   int         ir_got;

   initial begin
      ir_got = 0;
      rx_sin_char = '0;
      rx_sir_char = '0;
      tx_char_ready = 1'b0;
   end

   // pulse on one line only, then one idle edge
   task automatic send(input logic ir, input logic [7:0] d);
      if (ir) rx_sir_char <= '{1'b1, d};
      else rx_sin_char <= '{1'b1, d};
      @(posedge clk);
      rx_sin_char <= '{1'b0, ~rx_sin_char.data};
      rx_sir_char <= '{1'b0, ~rx_sir_char.data};
      @(posedge clk);
   endtask

   // slow at random even when not stalled
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_char_ready <= 1'b0;
      end else begin
         if (tx_char.valid && tx_char_ready) got_q.push_back(tx_char.data);
         if (tx_char.valid && tx_char_ready && ir_mode) ir_got++;
         tx_char_ready <= !stall && ($urandom % 3 != 0);
      end
   end
endmodule

// ### verification/tb_uart_shadow_data_port.sv
// Purpose: self-checking bench of the uart shadow data port
// Assumes: apb master leaves one idle cycle after each transfer
// Notes:   fifo depths cut to 4 so full cases stay short
`timescale 1ns/1ps
module tb_uart_shadow_data_port;
   import usdp_pkg::*;
   localparam int RXD = 4;
   localparam int TXD = 4;
   logic             clk;
   logic             resetn;
   usdp_apb_req_type req;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   usdp_char_type    sin_c;
   usdp_char_type    sir_c;
   usdp_char_type    tx_c;
   logic             tx_rdy;
   logic             ir;
   logic             stall;
   int               bad_count;
   int               n_compared;
   logic [31:0]      q;
   logic             e;
   logic [7:0]       d;
   logic [7:0]       exp_q[$];
   logic [7:0]       r_q[$];

   usdp_port #(.RX_DEPTH(RXD), .TX_DEPTH(TXD)) i_usdp_port (
      .clk(clk), .resetn(resetn), .apb_req(req), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_sin_char(sin_c), .rx_sir_char(sir_c), .tx_char(tx_c),
      .tx_char_ready(tx_rdy), .ir_mode(ir));

   usdp_line_model i_usdp_line_model (
      .clk(clk), .resetn(resetn), .ir_mode(ir), .tx_char(tx_c), .tx_char_ready(tx_rdy),
      .rx_sin_char(sin_c), .rx_sir_char(sir_c), .stall(stall));

   always #4 clk = ~clk;

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
      n_compared++;
      if (seen !== want) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
      end
   endtask

   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // release then idle one edge, so psel is never driven twice in a step
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      req <= '{a, 1'b1, 1'b0, w, wd};
      @(posedge clk);
      req.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      if (n >= 20) chk("apb answer", 32'h0000_0000, 32'h0000_0001);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input string what, input logic [31:0] a, input logic [31:0] want);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, q, want);
   endtask

   function automatic logic [31:0] stat_exp(input logic dr, ovr, txf, rxf, tx_holding_empty);
      return {26'h0, tx_holding_empty, 1'b0, rxf, txf, ovr, dr};
   endfunction

   function automatic logic [31:0] alias_addr();
      return SHADOW_BASE + 32'(WORD_BYTES * ($urandom % SHADOW_WORDS));
   endfunction

   task automatic drain();
      for (int k = 0; k < 300 && i_usdp_line_model.got_q.size() < exp_q.size(); k++)
         @(posedge clk);
      repeat (20) @(posedge clk);
      chk("tx count", i_usdp_line_model.got_q.size(), exp_q.size());
      foreach (exp_q[i]) chk("tx char", i_usdp_line_model.got_q[i], exp_q[i]);
      exp_q.delete();
      i_usdp_line_model.got_q.delete();
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      give_verdict();
   end

   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      req = '0;
      stall = 1'b0;
      bad_count = 0;
      n_compared = 0;
      void'($urandom(6));
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      rd("data reset", DATA5_ADDR, 32'h0000_0000);
      rd("stat reset", STAT_ADDR, stat_exp(0, 0, 0, 0, 1));
      $display("test reset done");

      apb(1'b1, CTRL_ADDR, 32'h0000_0002);
      chk("ir mode", 32'(ir), 32'h0000_0001);
      d = 8'($urandom);
      i_usdp_line_model.send(1'b0, ~d);
      i_usdp_line_model.send(1'b1, d);
      rd("ir char", alias_addr(), {24'h0, d});
      rd("ready cleared", STAT_ADDR, stat_exp(0, 0, 0, 0, 1));
      d = 8'($urandom);
      apb(1'b1, alias_addr(), {24'h0, d});
      exp_q.push_back(d);
      drain();
      chk("ir tx chars", i_usdp_line_model.ir_got, 32'h0000_0001);
      apb(1'b1, CTRL_ADDR, 32'h0000_0000);
      d = 8'($urandom);
      i_usdp_line_model.send(1'b0, d);
      rd("serial char", alias_addr(), {24'h0, d});
      $display("test line select done");

      i_usdp_line_model.send(1'b0, 8'($urandom));
      d = 8'($urandom);
      i_usdp_line_model.send(1'b0, d);
      rd("overrun set", STAT_ADDR, stat_exp(1, 1, 0, 0, 1));
      rd("newest kept", alias_addr(), {24'h0, d});
      rd("overrun clear", STAT_ADDR, stat_exp(0, 0, 0, 0, 1));
      $display("test overwrite done");
      rd("empty before write", STAT_ADDR, stat_exp(0, 0, 0, 0, 1));

      stall <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom);
         apb(1'b1, alias_addr(), {24'($urandom), d});
         if (i == 2) begin
            apb(1'b0, STAT_ADDR, 32'h0000_0000);
            chk("holding empty", 32'(q[STAT_TX_HOLDING_EMPTY]), 32'h0000_0000);
         end
         if (i != 2) exp_q.push_back(d);
      end
      stall <= 1'b0;
      drain();
      rd("holding back", STAT_ADDR, stat_exp(0, 0, 0, 0, 1));
      $display("test holding done");

      apb(1'b1, CTRL_ADDR, 32'h0000_0001);
      stall <= 1'b1;
      for (int i = 0; i < TXD + 4; i++) begin
         d = 8'($urandom);
         apb(1'b1, alias_addr(), {24'h0, d});
         if (i < TXD + 2) exp_q.push_back(d);
         if (i >= TXD) begin
            apb(1'b0, STAT_ADDR, 32'h0000_0000);
            chk("tx full", 32'(q[STAT_TX_FULL]), 32'(i > TXD));
         end
      end
      apb(1'b0, LEVEL_ADDR, 32'h0000_0000);
      chk("tx level", 32'(q[23:16]), TXD);
      stall <= 1'b0;
      drain();
      $display("test tx fifo done");

      for (int i = 0; i <= RXD; i++) begin
         d = 8'($urandom);
         r_q.push_back(d);
         i_usdp_line_model.send(1'b0, d);
      end
      rd("rx full", STAT_ADDR, stat_exp(1, 1, 0, 1, 1));
      for (int i = 0; i < RXD; i++) rd("rx head", alias_addr(), {24'h0, r_q[i]});
      rd("rx empty", alias_addr(), 32'h0000_0000);
      rd("rx idle", STAT_ADDR, stat_exp(0, 0, 0, 0, 1));
      $display("test rx fifo done");

      apb(1'b0, LEVEL_ADDR + 32'h0000_0010, 32'h0000_0000);
      chk("unmapped err", 32'(e), 32'h0000_0001);
      chk("unmapped data", q, 32'h0000_0000);
      apb(1'b1, DATA6_ADDR + 32'h0000_0001, 32'h0000_00a5);
      chk("misaligned err", 32'(e), 32'h0000_0001);
      drain();
      $display("test refusals done");
      give_verdict();
   end
endmodule
